// *** design/fpfe_pkg.sv ***
// fpfe_pkg: shared constants for the four-phase fetch/execute sequencer
// assumes: single 200 MHz system clock, synchronous active-high reset
package fpfe_pkg;
    localparam int PC_W        = 11;            // program counter width
    localparam int IW_W        = 16;            // instruction word width
    localparam int DW_W        = 8;             // data path width
    localparam int DA_W        = 7;             // data memory address width
    localparam logic [10:0] RESET_VECTOR = 11'h000; // fetch address after reset
    localparam logic [6:0]  PC_LOW_ADDR  = 7'h06;   // program counter low byte location
    localparam logic [6:0]  IND_ADDR     = 7'h00;   // indirect access window
    localparam logic [6:0]  MP_ADDR      = 7'h01;   // indirect pointer location
    localparam int PAGE_BITS   = 8;             // 256-location page

    // instruction major opcode, bits [15:12]
    localparam logic [3:0] OP_NOP  = 4'h0;
    localparam logic [3:0] OP_ADD  = 4'h1;
    localparam logic [3:0] OP_SUB  = 4'h2;
    localparam logic [3:0] OP_AND  = 4'h3;
    localparam logic [3:0] OP_OR   = 4'h4;
    localparam logic [3:0] OP_XOR  = 4'h5;
    localparam logic [3:0] OP_RR   = 4'h6;
    localparam logic [3:0] OP_RL   = 4'h7;
    localparam logic [3:0] OP_INC  = 4'h8;
    localparam logic [3:0] OP_DEC  = 4'h9;
    localparam logic [3:0] OP_MOVA = 4'hA;     // acc <- mem
    localparam logic [3:0] OP_MOVM = 4'hB;     // mem <- acc
    localparam logic [3:0] OP_SZ   = 4'hC;     // skip if mem zero
    localparam logic [3:0] OP_JMP  = 4'hD;
    localparam logic [3:0] OP_MOVI = 4'hE;     // acc <- immediate
    localparam logic [3:0] OP_CALL = 4'hF;     // jump; return stack kept outside this block

    typedef enum logic [1:0] {
        FPFE_PH_T1,
        FPFE_PH_T2,
        FPFE_PH_T3,
        FPFE_PH_T4
    } fpfe_phase_t;
endpackage : fpfe_pkg

// *** design/fpfe_alu.sv ***
// fpfe_alu: 8-bit combinational arithmetic-logic unit
// assumes: operands arrive from the accumulator and data memory
`timescale 1ns/1ps
module fpfe_alu
    import fpfe_pkg::*;
(
    input  wire logic [3:0]      i_op,       // major opcode
    input  wire logic [DW_W-1:0] i_acc,      // accumulator operand
    input  wire logic [DW_W-1:0] i_opnd,     // memory or immediate operand
    output logic      [DW_W-1:0] o_res,      // result
    output logic                 o_zero      // result is zero, for skip decision
);
    // one adder serves add, sub, inc and dec
    logic [DW_W-1:0] addend;
    logic [DW_W-1:0] sum;
    assign addend = (i_op == OP_SUB) ? ~i_opnd :
                    (i_op == OP_INC) ? 8'h01 :
                    (i_op == OP_DEC) ? 8'hFF : i_opnd;
    assign sum = (i_op == OP_INC || i_op == OP_DEC) ? i_opnd + addend
               : i_acc + addend + {7'h00, (i_op == OP_SUB)};

    // result select
    always_comb
    begin
        unique case (i_op)
            OP_ADD, OP_SUB, OP_INC, OP_DEC: o_res = sum;
            OP_AND:  o_res = i_acc & i_opnd;
            OP_OR:   o_res = i_acc | i_opnd;
            OP_XOR:  o_res = i_acc ^ i_opnd;
            OP_RR:   o_res = {i_opnd[0], i_opnd[DW_W-1:1]};
            OP_RL:   o_res = {i_opnd[DW_W-2:0], i_opnd[DW_W-1]};
            OP_MOVM: o_res = i_acc;         // store carries the accumulator to memory
            default: o_res = i_opnd;        // moves and branch decisions pass operand
        endcase
    end
    assign o_zero = (o_res == 8'h00);
endmodule : fpfe_alu

// *** design/fpfe_core.sv ***
// fpfe_core: four-phase fetch/execute sequencer with 8-bit accumulator data path
// assumes: program memory answers combinationally on o_pmem_addr; clock source
// selection feeds an external clock mux, this block sees one clock.
// How it works
// - four non-overlapping phases repeat in order
// - PC increments and fetch happen in T1
// - T2 to T4 decode and execute
// - fetch overlaps execute, one per cycle
// - PC-changing instructions take one extra cycle
// - 8-bit ALU does arithmetic, logic, rotate
// - operands and results pass the accumulator; inc, dec, rotate work in memory
// - fast or slow oscillator selects system clock
// - control registers reachable direct and indirect
// - branch: execute branch, then fetch target
// - taken skip discards prefetch, dummy cycle
// - PC low write jumps within page, dummy
// - fetching starts at location zero after reset
`timescale 1ns/1ps
module fpfe_core
    import fpfe_pkg::*;
#(
    parameter int DMEM_DEPTH = 128            // data memory locations
)
(
    input  wire logic              i_clk_sys,     // system clock
    input  wire logic              i_sys_rst,     // synchronous reset, active high
    input  wire logic              i_osc_sel_slow, // 1 selects slow internal oscillator
    input  wire logic [IW_W-1:0]   i_pmem_data,   // program word at o_pmem_addr
    output logic      [PC_W-1:0]   o_pmem_addr,   // fetch address
    output logic      [3:0]        o_phase,       // one-hot instruction_phase_clocks
    output logic      [DW_W-1:0]   o_acc,         // accumulator
    output logic      [PC_W-1:0]   o_pc,          // program counter
    output logic                   o_dummy,       // current cycle is a dummy
    output logic                   o_osc_sel_slow, // clock source request to mux
    output logic                   o_instr_done   // pulse: an instruction retired
);
    // elaboration stops here: a smaller store cannot hold the mapped control locations
    if (DMEM_DEPTH < 8 || DMEM_DEPTH > 128)
    begin : g_bad_depth
        $error("fpfe_core: DMEM_DEPTH must be 8..128");
    end

    // phase sequencer and pipeline state
    fpfe_phase_t      phase_ff, nxt_phase;        // current phase
    logic [PC_W-1:0]  pc_ff;                      // program counter
    logic [IW_W-1:0]  ir_ff;                      // instruction in execute
    logic [IW_W-1:0]  pf_ff;                      // prefetched instruction
    logic             pf_vld_ff;                  // prefetch usable
    logic             ir_vld_ff;                  // execute slot holds a real instruction
    logic             dummy_ff;                   // registered copy of an empty execute slot
    logic [DW_W-1:0]  acc_ff;                     // accumulator
    logic [DW_W-1:0]  mp_ff;                      // indirect pointer
    logic [DW_W-1:0]  dmem_ff [DMEM_DEPTH];       // data memory, flip-flops
    logic [DW_W-1:0]  res_ff;                     // ALU result latched in T3
    logic             zero_ff;                    // ALU zero latched in T3
    logic [3:0]       phase_oh_ff;                // registered phase output
    logic             done_ff;                    // retire pulse
    logic             osc_ff;                     // registered clock select

    // decode of the execute slot
    logic [3:0]       op;
    logic [DA_W-1:0]  dir_addr;
    logic [DA_W-1:0]  eff_addr;
    logic [DW_W-1:0]  mem_rd;
    logic [DW_W-1:0]  operand;
    logic [DW_W-1:0]  alu_res;
    logic             alu_zero;
    logic             exec_ok;
    logic             is_jump;
    logic             wr_mem;
    logic             wr_acc;
    logic             pc_low_hit;
    logic             skip_hit;
    logic             redirect;
    logic [PC_W-1:0]  target;

    assign op       = ir_ff[15:12];
    assign dir_addr = ir_ff[DA_W-1:0];
    // indirect window redirects through the pointer
    assign eff_addr = (dir_addr == IND_ADDR) ? mp_ff[DA_W-1:0] : dir_addr;
    assign mem_rd   = (eff_addr == PC_LOW_ADDR) ? pc_ff[7:0]
                    : (eff_addr == MP_ADDR)  ? mp_ff
                    : (32'(eff_addr) < DMEM_DEPTH) ? dmem_ff[eff_addr] : 8'h00;
    assign operand  = (op == OP_MOVI) ? ir_ff[7:0] : mem_rd;
    assign exec_ok  = ir_vld_ff;
    assign is_jump  = (op == OP_JMP) || (op == OP_CALL);
    assign wr_mem   = exec_ok && (op == OP_MOVM || op == OP_INC || op == OP_DEC
                               || op == OP_RR || op == OP_RL);
    assign wr_acc   = exec_ok && !wr_mem && !is_jump && op != OP_NOP && op != OP_SZ;
    assign pc_low_hit = wr_mem && (eff_addr == PC_LOW_ADDR);
    assign skip_hit = exec_ok && (op == OP_SZ) && zero_ff;
    assign redirect = exec_ok && (is_jump || pc_low_hit || skip_hit);
    // in-page jump keeps the page bits
    assign target   = is_jump ? ir_ff[PC_W-1:0]
                    : pc_low_hit ? {pc_ff[PC_W-1:PAGE_BITS], res_ff}
                    : pc_ff;                                         // skip: already past

    fpfe_alu u_alu
    (
        .i_op   (op),
        .i_acc  (acc_ff),
        .i_opnd (operand),
        .o_res  (alu_res),
        .o_zero (alu_zero)
    );

    // phase order T1 -> T2 -> T3 -> T4 -> T1
    always_comb
    begin
        unique case (phase_ff)
            FPFE_PH_T1: nxt_phase = FPFE_PH_T2;
            FPFE_PH_T2: nxt_phase = FPFE_PH_T3;
            FPFE_PH_T3: nxt_phase = FPFE_PH_T4;
            FPFE_PH_T4: nxt_phase = FPFE_PH_T1;
        endcase
    end

    // phase register, held at T1 during reset
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            phase_ff <= FPFE_PH_T1;
        else
            phase_ff <= nxt_phase;
    end

    // program counter and fetch
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            pc_ff     <= RESET_VECTOR;
            pf_ff     <= 16'h0000;
            pf_vld_ff <= 1'b0;
        end
        else if (phase_ff == FPFE_PH_T1)
        begin
            // fetch at end of T1 and advance; overlaps execute of ir_ff
            pf_ff     <= i_pmem_data;
            pf_vld_ff <= 1'b1;
            pc_ff     <= pc_ff + 11'h001;
        end
        else if (phase_ff == FPFE_PH_T4 && redirect)
        begin
            pc_ff     <= target;
            pf_vld_ff <= 1'b0;
        end
    end

    // hand prefetch to execute at the end of each instruction cycle
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            ir_ff     <= 16'h0000;
            ir_vld_ff <= 1'b0;
            dummy_ff  <= 1'b1;
        end
        else if (phase_ff == FPFE_PH_T4)
        begin
            // a redirect turns the next slot into a dummy while refetching
            ir_ff     <= pf_ff;
            ir_vld_ff <= pf_vld_ff && !redirect;
            dummy_ff  <= !(pf_vld_ff && !redirect);
        end
    end

    // execute: latch ALU in T3, write back in T4
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            res_ff  <= 8'h00;
            zero_ff <= 1'b0;
        end
        else if (phase_ff == FPFE_PH_T3)
        begin
            res_ff  <= alu_res;
            zero_ff <= (op == OP_SZ) ? (operand == 8'h00) : alu_zero;
        end
    end

    // architectural writes only from a real instruction in T4
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            acc_ff <= 8'h00;
            mp_ff  <= 8'h00;
        end
        else if (phase_ff == FPFE_PH_T4)
        begin
            if (wr_acc)
                acc_ff <= res_ff;
            if (wr_mem && eff_addr == MP_ADDR)
                mp_ff <= res_ff;
        end
    end

    // data memory; contents not cleared by reset, like plain RAM
    genvar g;
    generate
        for (g = 0; g < DMEM_DEPTH; g++)
        begin : g_dmem
            always_ff @(posedge i_clk_sys)
            begin
                if (phase_ff == FPFE_PH_T4 && wr_mem && !i_sys_rst
                    && 32'(eff_addr) == g && eff_addr != PC_LOW_ADDR && eff_addr != MP_ADDR)
                    dmem_ff[g] <= res_ff;
            end
        end
    endgenerate

    // registered outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            phase_oh_ff <= 4'h1;
            done_ff     <= 1'b0;
            osc_ff      <= 1'b0;
        end
        else
        begin
            phase_oh_ff <= 4'h1 << nxt_phase;
            done_ff     <= (phase_ff == FPFE_PH_T4) && exec_ok;
            osc_ff      <= i_osc_sel_slow;
        end
    end

    assign o_pmem_addr    = pc_ff;
    assign o_pc           = pc_ff;
    assign o_phase        = phase_oh_ff;
    assign o_acc          = acc_ff;
    assign o_dummy        = dummy_ff;
    assign o_osc_sel_slow = osc_ff;
    assign o_instr_done   = done_ff;
endmodule : fpfe_core

// *** verif/fpfe_core_asserts.sv ***
// fpfe_core_asserts: port-level timing checks for the four-phase sequencer
// assumes: bound onto fpfe_core, one clock, synchronous active-high reset
`timescale 1ns/1ps
module fpfe_core_chk
    import fpfe_pkg::*;
(
    input wire logic              i_clk_sys,      // system clock
    input wire logic              i_sys_rst,      // synchronous reset
    input wire logic              i_osc_sel_slow, // oscillator request in
    input wire logic [IW_W-1:0]   i_pmem_data,    // fetched word
    input wire logic [PC_W-1:0]   o_pmem_addr,    // fetch address
    input wire logic [3:0]        o_phase,        // one-hot phase
    input wire logic [DW_W-1:0]   o_acc,          // accumulator
    input wire logic [PC_W-1:0]   o_pc,           // program counter
    input wire logic              o_dummy,        // empty execute slot
    input wire logic              o_osc_sel_slow, // oscillator request out
    input wire logic              o_instr_done    // retire pulse
);
    // the design still obeys reset at the release edge, so checks stay off one edge longer
    logic rst_seen_ff;                            // reset as taken by the last edge
    always_ff @(posedge i_clk_sys)
    begin
        rst_seen_ff <= i_sys_rst;
    end

    // one domain, so clock and reset are given once here
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst || rst_seen_ff);

    a_phase_onehot: assert property ($onehot(o_phase))
        else $error("phase is not one-hot");
    a_phase_order: assert property (!o_phase[3] |=> o_phase == {$past(o_phase[2:0]), 1'h0})
        else $error("phase did not advance by one");
    a_phase_wrap: assert property (o_phase[3] |=> o_phase == 4'h1)
        else $error("phase did not wrap to the fetch phase");
    a_pc_mid_hold: assert property ((o_phase[1] || o_phase[2]) |=> $stable(o_pc))
        else $error("program counter moved mid-cycle");
    a_fetch_addr: assert property (o_pmem_addr == o_pc)
        else $error("fetch address differs from program counter");
    a_done_slot: assert property (o_instr_done |-> o_phase[0] && $past(o_phase[3]))
        else $error("retire pulse outside the slot after the last phase");
    a_done_pulse: assert property (o_instr_done |=> !o_instr_done)
        else $error("retire pulse longer than one cycle");
    // accumulator writes land only at the close of the last phase
    a_acc_t4_only: assert property (!o_phase[3] |=> $stable(o_acc))
        else $error("accumulator changed outside the last phase");
    a_dummy_quiet: assert property (o_dummy && o_phase[3] |=> $stable(o_acc) && !o_instr_done)
        else $error("dummy cycle wrote or retired");
    a_osc_follow: assert property (1'h1 |=> o_osc_sel_slow == $past(i_osc_sel_slow))
        else $error("oscillator request not passed on");
    a_reset_start: assert property ($fell(i_sys_rst) |-> o_phase == 4'h1 && o_pc == RESET_VECTOR)
        else $error("sequencer not at fetch phase and vector after reset");
endmodule : fpfe_core_chk

bind fpfe_core fpfe_core_chk i_fpfe_core_chk (.i_clk_sys, .i_sys_rst, .i_osc_sel_slow,
    .i_pmem_data, .o_pmem_addr, .o_phase, .o_acc, .o_pc, .o_dummy, .o_osc_sel_slow,
    .o_instr_done);

// *** verif/fpfe_core_tb_top.sv ***
// fpfe_core_tb_top: directed programs for the four-phase sequencer
// assumes: combinational program memory modelled by a testbench array
`timescale 1ns/1ps
module fpfe_core_tb_top
    import fpfe_pkg::*;
;
    logic            clk_sys = 1'h0;  // 200 MHz
    logic            sys_rst = 1'h1;  // held from time zero
    logic            osc_in  = 1'h0;  // oscillator request
    logic [IW_W-1:0] rom [0:2047];    // program store
    wire  [IW_W-1:0] pmem_data;
    wire  [PC_W-1:0] pmem_addr;
    wire  [PC_W-1:0] pc;
    wire  [3:0]      phase;
    wire  [DW_W-1:0] acc;
    wire             dummy;
    wire             osc_out;
    wire             done;
    int              fail_count = 0;
    int              tests_run  = 0;
    int              cycles     = 0;

    always #2.5 clk_sys = ~clk_sys;
    assign pmem_data = rom[pmem_addr];

    fpfe_core i_fpfe_core (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_osc_sel_slow(osc_in),
        .i_pmem_data(pmem_data), .o_pmem_addr(pmem_addr), .o_phase(phase), .o_acc(acc),
        .o_pc(pc), .o_dummy(dummy), .o_osc_sel_slow(osc_out), .o_instr_done(done));

    function automatic logic [15:0] ins(input logic [3:0] op, input logic [11:0] a);
        return {op, a};
    endfunction : ins

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // reload from all-NOP memory, then reset for five cycles
    task automatic boot;
        foreach (rom[i]) rom[i] = '0;
    endtask : boot

    task automatic rst5;
        @(posedge clk_sys) sys_rst <= 1'h1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
    endtask : rst5

    // wait for the next retire, bounded, then judge spacing and accumulator
    task automatic run(input logic [15:0] g_exp, input logic [7:0] a_exp);
        int g;
        g = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            g++;
        end while (done !== 1'h1 && g < 40);
        chk(16'(g), g_exp);
        chk(16'(acc), 16'(a_exp));
    endtask : run

    task automatic t_straight;
        logic [7:0] ea [15] = '{8'h5A, 8'h5A, 8'h03, 8'h5D, 8'h03, 8'hA9, 8'h03, 8'h02,
                                8'h03, 8'h5B, 8'h03, 8'h59, 8'h10, 8'h10, 8'h5A};
        logic [3:0] ops [5] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};
        boot();
        rom[0] = ins(OP_MOVI, 12'h05A);
        rom[1] = ins(OP_MOVM, 12'h010);
        for (int k = 0; k < 5; k++)
        begin
            rom[2+2*k] = ins(OP_MOVI, 12'h003);
            rom[3+2*k] = ins(ops[k], 12'h010);
        end
        // pointer at 1 then a read through the indirect window
        rom[12] = ins(OP_MOVI, 12'h010);
        rom[13] = ins(OP_MOVM, 12'h001);
        rom[14] = ins(OP_MOVA, 12'h000);
        rst5();
        for (int i = 0; i < 15; i++)
        begin
            run(i == 0 ? 16'h0008 : 16'h0004, ea[i]);
            chk(16'(phase), 16'h0001);
        end
        $display("straight-line test finished");
    endtask : t_straight

    // read-modify-write ops land in memory and are read back through the accumulator
    task automatic t_rmw;
        logic [3:0] ops [4] = '{OP_INC, OP_DEC, OP_RR, OP_RL};
        logic [7:0] ev [4]  = '{8'h82, 8'h81, 8'hC0, 8'h81};
        boot();
        rom[0] = ins(OP_MOVI, 12'h081);
        rom[1] = ins(OP_MOVM, 12'h014);
        for (int k = 0; k < 4; k++)
        begin
            rom[2+2*k] = ins(ops[k], 12'h014);
            rom[3+2*k] = ins(OP_MOVA, 12'h014);
        end
        rst5();
        run(16'h0008, 8'h81);
        run(16'h0004, 8'h81);
        for (int k = 0; k < 4; k++)
        begin
            // ev[3] doubles as the starting value 81
            run(16'h0004, ev[(k+3)%4]);
            run(16'h0004, ev[k]);
        end
        $display("memory update test finished");
    endtask : t_rmw

    task automatic t_flow;
        boot();
        rom[0] = ins(OP_JMP, 12'h020);
        rom[1] = ins(OP_MOVI, 12'h011);
        rom[32] = ins(OP_MOVI, 12'h077);
        rom[33] = ins(OP_CALL, 12'h040);
        rom[34] = ins(OP_MOVI, 12'h011);
        rom[64] = ins(OP_MOVI, 12'h066);
        rst5();
        run(16'h0008, 8'h00);
        run(16'h0008, 8'h77);
        run(16'h0004, 8'h77);
        run(16'h0008, 8'h66);
        $display("jump and call test finished");
    endtask : t_flow

    task automatic t_skip;
        boot();
        rom[0] = ins(OP_MOVI, 12'h000);
        rom[1] = ins(OP_MOVM, 12'h012);
        rom[2] = ins(OP_SZ, 12'h012);
        rom[3] = ins(OP_MOVI, 12'h033);
        rom[4] = ins(OP_MOVI, 12'h044);
        rom[5] = ins(OP_MOVI, 12'h007);
        rom[6] = ins(OP_MOVM, 12'h013);
        rom[7] = ins(OP_SZ, 12'h013);
        rom[8] = ins(OP_MOVI, 12'h055);
        rst5();
        run(16'h0008, 8'h00);
        run(16'h0004, 8'h00);
        run(16'h0004, 8'h00);
        run(16'h0008, 8'h44);
        run(16'h0004, 8'h07);
        run(16'h0004, 8'h07);
        run(16'h0004, 8'h07);
        run(16'h0004, 8'h55);
        $display("skip test finished");
    endtask : t_skip

    task automatic t_pc_low;
        boot();
        rom[0] = ins(OP_JMP, 12'h105);
        rom[261] = ins(OP_MOVI, 12'h030);
        rom[262] = ins(OP_MOVM, 12'h006);
        rom[263] = ins(OP_MOVI, 12'h011);
        rom[304] = ins(OP_MOVI, 12'h099);
        rst5();
        run(16'h0008, 8'h00);
        run(16'h0008, 8'h30);
        run(16'h0004, 8'h30);
        run(16'h0008, 8'h99);
        chk(16'(pc[10:8]), 16'h0001);
        $display("low-byte jump test finished");
    endtask : t_pc_low

    // reset in mid-instruction with the low-byte program still loaded
    task automatic t_reset;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(16'({phase, dummy, done}), 16'h0006);
        chk(16'(pc), 16'h0000);
        @(posedge clk_sys) sys_rst <= 1'h0;
        run(16'h0008, 8'h00);
        run(16'h0008, 8'h30);
        $display("mid-run reset test finished");
    endtask : t_reset

    task automatic t_osc;
        @(posedge clk_sys) osc_in <= 1'h1;
        @(posedge clk_sys);
        #1;
        chk(16'(osc_out), 16'h0001);
        @(posedge clk_sys) osc_in <= 1'h0;
        @(posedge clk_sys);
        #1;
        chk(16'(osc_out), 16'h0000);
        $display("clock select test finished");
    endtask : t_osc

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    initial
    begin
        t_straight();
        t_rmw();
        t_flow();
        t_skip();
        t_pc_low();
        t_reset();
        t_osc();
        end_of_test();
    end
endmodule : fpfe_core_tb_top
